// *** rtl/wrb_defines.vh ***
// constants for the wiper register bank
`ifndef WRB_DEFINES_VH
`define WRB_DEFINES_VH

// system clock period in ns
`define WRB_CLK_NS 40
// byte addresses
`define WRB_ADDR_WIPER 8'h00
`define WRB_ADDR_RSVD 8'h01
`define WRB_ADDR_ACCESS 8'h02
// access-control values
`define WRB_AC_BOTH 8'h00
`define WRB_AC_VOL 8'h80
// reset values
`define WRB_WIPER_RST 8'h80
`define WRB_STORE_RST 8'h80
`define WRB_ACCESS_RST 8'h00
`define WRB_RSVD_VALUE 8'h00
// seven-bit bus identification
`define WRB_BUS_ID 7'h28
// self-timed write cycle, typical and maximum, in ms
`define WRB_TWC_TYP_MS 12
`define WRB_TWC_MAX_MS 20
`define WRB_TWC_CYC (`WRB_TWC_TYP_MS * 1000000 / `WRB_CLK_NS)
// wait before the startup store is read, in ns
`define WRB_BOOT_NS 1000
`define WRB_BOOT_CYC ((`WRB_BOOT_NS + `WRB_CLK_NS - 1) / `WRB_CLK_NS)

`endif

// *** rtl/wrb_wiper_bank.v ***
// wiper register bank with its two-wire serial slave and non-volatile store
`timescale 1ns/1ns
`include "wrb_defines.vh"

module wrb_wiper_bank #(
    parameter [19:0] WRITE_CYCLES = `WRB_TWC_CYC
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // two-wire serial link
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // write protect, low blocks writes
    input wire write_protect_n_i,
    // potentiometer control and status
    output reg [7:0] wiper_position_o,
    output reg nv_busy_o,
    output reg boot_done_o
);

    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ID = 7'h02;
    localparam [6:0] S_ADR = 7'h04;
    localparam [6:0] S_DAT = 7'h08;
    localparam [6:0] S_RD = 7'h10;
    localparam [6:0] S_IGN = 7'h20;
    localparam [6:0] S_NVW = 7'h40;

    // read multiplexer for the three addresses
    function [7:0] read_byte;
        input [7:0] addr;
        input [7:0] access;
        input [7:0] wiper;
        input [7:0] store;
        begin
            if (addr == `WRB_ADDR_WIPER) begin
                if (access == `WRB_AC_VOL)
                    read_byte = wiper;
                else
                    read_byte = store;
            end else if (addr == `WRB_ADDR_ACCESS) begin
                read_byte = access;
            end else begin
                read_byte = `WRB_RSVD_VALUE;
            end
        end
    endfunction

    reg scl_m;
    reg scl_s;
    reg scl_d;
    reg sda_m;
    reg sda_s;
    reg sda_d;
    reg wp_m;
    reg wp_s;
    reg [6:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] reg_addr;
    reg [7:0] tx_byte;
    reg ack_drive;
    reg [7:0] access_control;
    // non-volatile: keeps its contents across rst_n_i, ships holding midscale
    reg [7:0] startup_value_store = `WRB_STORE_RST;
    reg [7:0] nv_data;
    reg nv_pending;
    reg [19:0] nv_cnt;
    reg [4:0] boot_cnt;

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    wire receiving = (state == S_ID) | (state == S_ADR) | (state == S_DAT);
    wire [7:0] rd_now = read_byte(reg_addr, access_control, wiper_position_o,
                                  startup_value_store);
    wire nv_commit = (state == S_NVW) && (nv_cnt == WRITE_CYCLES - 20'h00001);

    // store update at the end of the self-timed cycle, untouched by rst_n_i
    always @(posedge clk_sys_i) begin
        if (rst_n_i && boot_done_o && nv_commit) begin
            startup_value_store <= nv_data;
        end
    end

    // pin synchronisers
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            wp_m <= 1'b1;
            wp_s <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_d <= sda_s;
            wp_m <= write_protect_n_i;
            wp_s <= wp_m;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            reg_addr <= 8'h00;
            tx_byte <= 8'h00;
            ack_drive <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            wiper_position_o <= `WRB_WIPER_RST;
            access_control <= `WRB_ACCESS_RST;
            nv_data <= 8'h00;
            nv_pending <= 1'b0;
            nv_cnt <= 20'h00000;
            nv_busy_o <= 1'b0;
            boot_cnt <= 5'h00;
            boot_done_o <= 1'b0;
        end else if (!boot_done_o) begin
            // hold midscale until the store reads reliably, then recall it
            if (boot_cnt == `WRB_BOOT_CYC - 1) begin
                boot_done_o <= 1'b1;
                wiper_position_o <= startup_value_store;
            end else begin
                boot_cnt <= boot_cnt + 5'h01;
            end
        end else if (state == S_NVW) begin
            // self-timed cycle, link fully ignored
            sda_oe_o <= 1'b0;
            if (nv_commit) begin
                nv_busy_o <= 1'b0;
                state <= S_IDLE;
            end else begin
                nv_cnt <= nv_cnt + 20'h00001;
            end
        end else if (stop_cond) begin
            ack_drive <= 1'b0;
            sda_oe_o <= 1'b0;
            nv_pending <= 1'b0;
            if (nv_pending) begin
                nv_cnt <= 20'h00000;
                nv_busy_o <= 1'b1;
                state <= S_NVW;
            end else begin
                state <= S_IDLE;
            end
        end else if (start_cond) begin
            ack_drive <= 1'b0;
            sda_oe_o <= 1'b0;
            nv_pending <= 1'b0;
            bit_cnt <= 4'h0;
            state <= S_ID;
        end else if (scl_rise) begin
            if (receiving && !ack_drive && bit_cnt < 4'h8) begin
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (state == S_RD && !ack_drive) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end else if (scl_fall) begin
            if (ack_drive) begin
                // acknowledge slot over
                ack_drive <= 1'b0;
                bit_cnt <= 4'h0;
                if (state == S_RD) begin
                    tx_byte <= rd_now;
                    sda_oe_o <= ~rd_now[7];
                end else begin
                    sda_oe_o <= 1'b0;
                end
            end else if (state == S_RD) begin
                if (bit_cnt == 4'h8) begin
                    sda_oe_o <= 1'b0;
                    state <= S_IGN;
                end else begin
                    tx_byte <= {tx_byte[6:0], 1'b0};
                    sda_oe_o <= ~tx_byte[6];
                end
            end else if (receiving && bit_cnt == 4'h8) begin
                case (state)
                    S_ID: begin
                        if (shreg[7:1] == `WRB_BUS_ID) begin
                            ack_drive <= 1'b1;
                            sda_oe_o <= 1'b1;
                            state <= shreg[0] ? S_RD : S_ADR;
                        end else begin
                            state <= S_IGN;
                        end
                    end
                    S_ADR: begin
                        reg_addr <= shreg;
                        ack_drive <= 1'b1;
                        sda_oe_o <= 1'b1;
                        state <= S_DAT;
                    end
                    S_DAT: begin
                        if (wp_s) begin
                            ack_drive <= 1'b1;
                            sda_oe_o <= 1'b1;
                            // data takes effect on this falling edge
                            if (reg_addr == `WRB_ADDR_WIPER) begin
                                wiper_position_o <= shreg;
                                if (access_control == `WRB_AC_BOTH) begin
                                    nv_data <= shreg;
                                    nv_pending <= 1'b1;
                                end
                            end else if (reg_addr == `WRB_ADDR_ACCESS) begin
                                access_control <= shreg;
                            end
                            // reserved and unmapped addresses change nothing
                        end
                        state <= S_IGN;
                    end
                    default: begin
                        state <= S_IGN;
                    end
                endcase
            end
        end
    end

endmodule

// *** dv/wrb_wiper_bank_assertions.sv ***
// port-level checker for the wiper register bank
`timescale 1ns/1ns
module wrb_bank_chk #(
    parameter [19:0] WRITE_CYCLES = 20'd50
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // link and status
    input wire scl_i,
    input wire sda_i,
    input wire sda_oe_o,
    input wire [7:0] wiper_position_o,
    input wire nv_busy_o,
    input wire boot_done_o
);
    logic [20:0] busy_cnt;
    logic [3:0] hi_cnt;
    // busy length and time since the serial clock last went high
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt <= 21'h0;
            hi_cnt <= 4'h0;
        end else begin
            busy_cnt <= nv_busy_o ? busy_cnt + 21'h1 : 21'h0;
            hi_cnt <= !scl_i ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hf};
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_midscale: assert property ($rose(rst_n_i) |-> wiper_position_o == 8'h80)
        else $error("wiper not midscale after reset");
    a_boot_wait: assert property ($rose(rst_n_i) |-> !boot_done_o [*8])
        else $error("recall done too early");
    a_boot_hold: assert property (boot_done_o |=> boot_done_o)
        else $error("recall flag dropped");
    a_busy_quiet: assert property (nv_busy_o |-> !sda_oe_o)
        else $error("data line driven during write cycle");
    a_stop_starts: assert property ($rose(nv_busy_o) |-> scl_i && sda_i)
        else $error("write cycle began without a stop");
    a_busy_bound: assert property (nv_busy_o |-> busy_cnt <= WRITE_CYCLES)
        else $error("write cycle too long");
    a_busy_length: assert property ($fell(nv_busy_o) |-> busy_cnt + 21'h1 >= WRITE_CYCLES)
        else $error("write cycle too short");
    a_wiper_on_fall: assert property ($changed(wiper_position_o) && $past(boot_done_o)
        |-> hi_cnt <= 4'h2)
        else $error("wiper changed outside clock low");
    c_nv: cover property ($rose(nv_busy_o));
    c_wiper: cover property ($changed(wiper_position_o) && $past(boot_done_o));
    c_ack: cover property ($rose(sda_oe_o));
endmodule

bind wrb_wiper_bank wrb_bank_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
    .wiper_position_o(wiper_position_o), .nv_busy_o(nv_busy_o), .boot_done_o(boot_done_o));

// *** dv/wrb_i2c_master.sv ***
// two-wire bus master model for the wiper bank link
`timescale 1ns/1ns
`include "wrb_defines.vh"
module wrb_i2c_master (
    // serial link
    output logic scl_o,
    output logic pull_o,
    input wire sda_i
);
    localparam int Q = 80;
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    // off the system clock edges, then a fixed 320 ns bit period
    task automatic start;
        #(Q - ($time % 40) + 13) pull_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q pull_o = 1'b1;
        #Q scl_o = 1'b0;
    endtask
    task automatic stop;
        #Q pull_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q pull_o = 1'b0;
        #Q;
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [8:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            #Q pull_o = ~tx[i];
            #Q scl_o = 1'b1;
            #Q;
            if (i > 0) rx[i-1] = sda_i;
            ack = ~sda_i;
            #Q scl_o = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2;
        start();
        xfer({`WRB_BUS_ID, 2'b01}, r, k0);
        xfer({a, 1'b1}, r, k1);
        xfer({d, 1'b1}, r, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        start();
        xfer({`WRB_BUS_ID, 2'b01}, r, k0);
        xfer({a, 1'b1}, r, k1);
        start();
        xfer({`WRB_BUS_ID, 2'b11}, r, k2);
        xfer(9'h1ff, d, k3);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule

// *** dv/wrb_wiper_bank_tb.sv ***
// self-checking bench for the wiper register bank
`timescale 1ns/1ns
`include "wrb_defines.vh"
module wrb_wiper_bank_tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wp_n = 1'b1;
    logic scl, pull, ok;
    logic [7:0] d;
    wire sda_o, sda_oe_o, nv_busy_o, boot_done_o;
    wire [7:0] wiper;
    // open-drain data line with pull-up
    wire sda = ~(pull | sda_oe_o);
    int num_errors = 0;
    int num_checks = 0;
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    wrb_wiper_bank #(.WRITE_CYCLES(20'd1000)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .write_protect_n_i(wp_n),
        .wiper_position_o(wiper), .nv_busy_o(nv_busy_o), .boot_done_o(boot_done_o));
    wrb_i2c_master m (.scl_o(scl), .pull_o(pull), .sda_i(sda));
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp1(input string n, input logic e, input logic g);
        cmp8(n, {7'h0, e}, {7'h0, g});
    endtask
    task automatic do_reset;
        @(posedge clk_sys_i) #2 rst_n_i = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        #2 rst_n_i = 1'b1;
        for (int i = 0; i < 100 && boot_done_o !== 1'b1; i++) @(posedge clk_sys_i);
    endtask
    task automatic t_power_up;
        do_reset();
        cmp8("wiper", 8'h80, wiper);
        cmp1("boot done", 1'b1, boot_done_o);
        cmp1("sda out", 1'b0, sda_o);
        m.rd(`WRB_ADDR_WIPER, d, ok);
        cmp8("store", `WRB_STORE_RST, d);
        m.rd(`WRB_ADDR_ACCESS, d, ok);
        cmp8("access", `WRB_ACCESS_RST, d);
    endtask
    task automatic t_volatile;
        logic [7:0] v[3] = '{8'h00, 8'hff, 8'h5a};
        m.wr(`WRB_ADDR_ACCESS, `WRB_AC_VOL, ok);
        foreach (v[i]) begin
            m.wr(`WRB_ADDR_WIPER, v[i], ok);
            cmp8("wiper", v[i], wiper);
            m.rd(`WRB_ADDR_WIPER, d, ok);
            cmp8("wiper read", v[i], d);
            cmp1("busy", 1'b0, nv_busy_o);
        end
        m.wr(`WRB_ADDR_ACCESS, `WRB_AC_BOTH, ok);
        m.rd(`WRB_ADDR_WIPER, d, ok);
        cmp8("store", `WRB_STORE_RST, d);
    endtask
    task automatic t_nv_write;
        m.wr(`WRB_ADDR_WIPER, 8'hc3, ok);
        cmp8("wiper", 8'hc3, wiper);
        m.rd(`WRB_ADDR_WIPER, d, ok);
        cmp1("busy ack", 1'b0, ok);
        cmp1("busy", 1'b1, nv_busy_o);
        for (int i = 0; i < 2000 && nv_busy_o !== 1'b0; i++) @(posedge clk_sys_i);
        m.rd(`WRB_ADDR_WIPER, d, ok);
        cmp8("store", 8'hc3, d);
    endtask
    task automatic t_reserved;
        m.wr(`WRB_ADDR_RSVD, 8'h55, ok);
        m.rd(`WRB_ADDR_RSVD, d, ok);
        cmp8("reserved", `WRB_RSVD_VALUE, d);
        cmp1("busy", 1'b0, nv_busy_o);
        cmp8("wiper", 8'hc3, wiper);
    endtask
    task automatic t_protect_recall;
        @(posedge clk_sys_i) #2 wp_n = 1'b0;
        m.wr(`WRB_ADDR_WIPER, 8'h11, ok);
        cmp1("protect ack", 1'b0, ok);
        cmp8("wiper", 8'hc3, wiper);
        @(posedge clk_sys_i) #2 wp_n = 1'b1;
        do_reset();
        cmp8("recall", 8'hc3, wiper);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        t_power_up();
        t_volatile();
        t_nv_write();
        t_reserved();
        t_protect_recall();
        give_verdict();
    end
    initial begin
        #3000000;
        num_errors++;
        give_verdict();
    end
endmodule
